// file: design/smc_pkg.sv
package smc_pkg;

    // =========================================================
    // power control register layout
    // =========================================================
    localparam int        PCR_W          = 8;
    localparam int        PCR_SE_BIT     = 5;
    localparam int        PCR_SM_MSB     = 4;
    localparam int        PCR_SM_LSB     = 3;
    localparam logic [7:0] PCR_RESET     = 8'h00;
    localparam logic [7:0] PCR_OWN_MASK  = 8'h38;

    // =========================================================
    // timing
    // =========================================================
    localparam int CLK_PERIOD_NS        = 40;
    localparam int WAKE_HALT_CYCLES     = 4;
    localparam int STANDBY_WAKE_CYCLES  = 6;
    localparam int RUNNING_OSC_CYCLES   = 0;
    localparam int OSC_STARTUP_DEFAULT  = 16;
    localparam int CNT_W                = 12;

    // =========================================================
    // sleep modes and controller states
    // =========================================================
    typedef enum logic [1:0]
    {
        SMC_IDLE    = 2'h0,
        SMC_NOISE   = 2'h1,
        SMC_PDOWN   = 2'h2,
        SMC_STANDBY = 2'h3
    } smc_mode_e;

    typedef enum logic [1:0]
    {
        SMC_ACTIVE    = 2'h0,
        SMC_SLEEP     = 2'h1,
        SMC_WAKE_OSC  = 2'h3,
        SMC_WAKE_HALT = 2'h2
    } smc_state_e;

    // clock enable vector: core, program memory, peripheral,
    // converter, oscillator
    localparam int CLK_CORE = 4;
    localparam int CLK_PMEM = 3;
    localparam int CLK_PERI = 2;
    localparam int CLK_CONV = 1;
    localparam int CLK_OSC  = 0;
    localparam logic [4:0] CLK_ALL_ON = 5'h1F;

endpackage

// file: design/smc_sleep_controller.sv
module smc_sleep_controller import smc_pkg::*;
#(
    parameter int OSC_STARTUP_CYCLES = OSC_STARTUP_DEFAULT
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // core side
    input  wire logic         pcr_write,
    input  wire logic [7:0]   pcr_wdata,
    input  wire logic         sleep_instr,
    input  wire logic         crystal_clock_sel,
    output logic      [7:0]   power_control_reg,
    output logic              irq_service_start,
    output logic              reset_vector_start,
    output logic              storage_hold,
    output logic              sleeping,
    output logic      [1:0]   active_mode,
    // clock domain enables
    output logic              core_clock_domain,
    output logic              program_memory_clock,
    output logic              peripheral_clock_domain,
    output logic              converter_clock_domain,
    output logic              oscillator_en,
    // converter
    input  wire logic         converter_enabled,
    output logic              converter_start,
    // interrupt wake sources
    input  wire logic         external_interrupt_zero_irq,
    input  wire logic         external_interrupt_zero_enabled,
    input  wire logic         external_interrupt_zero_level_mode,
    input  wire logic         external_interrupt_zero,
    input  wire logic         pin_change_irq,
    input  wire logic         self_program_op_irq,
    input  wire logic         converter_done_irq,
    input  wire logic         timer_irq,
    input  wire logic         comparator_irq,
    input  wire logic         comparator_power_off,
    input  wire logic         other_io_irq,
    input  wire logic         watchdog_irq,
    // reset wake sources
    input  wire logic         ext_reset_n,
    input  wire logic         watchdog_reset_req,
    input  wire logic         brownout_reset_req
);

    // =========================================================
    // pin synchronisers
    // =========================================================
    logic [1:0] pins_sync;

    smc_sync2 #(.W(2)) u_pin_sync
    (
        .clk      (clk),
        .rst      (rst),
        .async_in ({external_interrupt_zero, ext_reset_n}),
        .sync_out (pins_sync)
    );

    logic external_interrupt_zero_pin_s;
    logic ext_reset_s;

    assign external_interrupt_zero_pin_s  = pins_sync[1];
    assign ext_reset_s = ~pins_sync[0];

    // =========================================================
    // helper functions
    // =========================================================
    function automatic logic [4:0] mode_clocks(input smc_mode_e m);
        logic [4:0] en;
        en = CLK_ALL_ON;
        unique case (m)
            SMC_IDLE:
            begin
                en[CLK_CORE] = 1'b0;
                en[CLK_PMEM] = 1'b0;
            end
            SMC_NOISE:
            begin
                en[CLK_CORE] = 1'b0;
                en[CLK_PMEM] = 1'b0;
                en[CLK_PERI] = 1'b0;
            end
            SMC_PDOWN:
                en = '0;
            SMC_STANDBY:
                en = 5'(1 << CLK_OSC);
        endcase
        return en;
    endfunction

    function automatic logic [CNT_W-1:0] startup_of(input smc_mode_e m);
        logic [CNT_W-1:0] c;
        c = CNT_W'(RUNNING_OSC_CYCLES);
        unique case (m)
            SMC_IDLE,
            SMC_NOISE:   c = CNT_W'(RUNNING_OSC_CYCLES);
            SMC_PDOWN:   c = CNT_W'(OSC_STARTUP_CYCLES);
            SMC_STANDBY: c = CNT_W'(STANDBY_WAKE_CYCLES);
        endcase
        return c;
    endfunction

    // =========================================================
    // power control register
    // =========================================================
    logic [7:0] next_pcr;
    smc_mode_e  choice_mode;
    logic       sleep_enable;

    assign sleep_enable = power_control_reg[PCR_SE_BIT];

    always_comb
    begin
        next_pcr = power_control_reg;
        if (pcr_write)
            next_pcr = pcr_wdata & PCR_OWN_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            power_control_reg <= PCR_RESET;
        else
            power_control_reg <= next_pcr;
    end

    // 11 without crystal falls back to power-down
    always_comb
    begin
        choice_mode = smc_mode_e'(
            power_control_reg[PCR_SM_MSB:PCR_SM_LSB]);
        if (choice_mode == SMC_STANDBY && !crystal_clock_sel)
            choice_mode = SMC_PDOWN;
    end

    // =========================================================
    // wake qualification
    // =========================================================
    logic external_interrupt_zero_level_wake;
    logic irq_wake;
    logic reset_wake;
    smc_mode_e cur_mode;

    // level source must stay low until serviced
    assign external_interrupt_zero_level_wake = external_interrupt_zero_enabled && external_interrupt_zero_level_mode
                           && !external_interrupt_zero_pin_s;

    assign reset_wake = ext_reset_s || watchdog_reset_req
                      || brownout_reset_req;

    always_comb
    begin
        irq_wake = 1'b0;
        unique case (cur_mode)
            SMC_IDLE:
                irq_wake = external_interrupt_zero_irq || pin_change_irq
                         || self_program_op_irq
                         || converter_done_irq || timer_irq
                         || other_io_irq || watchdog_irq
                         || (comparator_irq
                             && !comparator_power_off);
            SMC_NOISE:
                irq_wake = converter_done_irq
                         || self_program_op_irq
                         || external_interrupt_zero_level_wake || pin_change_irq
                         || watchdog_irq;
            SMC_PDOWN,
            SMC_STANDBY:
                irq_wake = external_interrupt_zero_level_wake || pin_change_irq
                         || watchdog_irq;
        endcase
    end

    // =========================================================
    // sequencer
    // =========================================================
    smc_state_e       state;
    smc_state_e       next_state;
    smc_mode_e        next_cur_mode;
    logic [4:0]       clk_en;
    logic [4:0]       next_clk_en;
    logic             next_irq_service;
    logic             next_reset_vector;
    logic             next_conv_start;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic             tmr_expire;

    smc_wake_timer #(.W(CNT_W)) u_wake_timer
    (
        .clk      (clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expire   (tmr_expire)
    );

    always_comb
    begin
        next_state        = state;
        next_cur_mode     = cur_mode;
        next_clk_en       = clk_en;
        next_irq_service  = 1'b0;
        next_reset_vector = 1'b0;
        next_conv_start   = 1'b0;
        tmr_load          = 1'b0;
        tmr_val           = '0;
        unique case (state)
            SMC_ACTIVE:
            begin
                if (sleep_instr && sleep_enable)
                begin
                    next_state    = SMC_SLEEP;
                    next_cur_mode = choice_mode;
                    next_clk_en   = mode_clocks(choice_mode);
                    next_conv_start = converter_enabled
                        && (choice_mode == SMC_IDLE
                            || choice_mode == SMC_NOISE);
                end
            end
            SMC_SLEEP:
            begin
                if (reset_wake)
                begin
                    next_state        = SMC_ACTIVE;
                    next_clk_en       = CLK_ALL_ON;
                    next_reset_vector = 1'b1;
                end
                else if (irq_wake)
                begin
                    next_state            = SMC_WAKE_OSC;
                    next_clk_en[CLK_OSC]  = 1'b1;
                    tmr_load              = 1'b1;
                    tmr_val               = startup_of(cur_mode);
                end
            end
            SMC_WAKE_OSC:
            begin
                if (reset_wake)
                begin
                    next_state        = SMC_ACTIVE;
                    next_clk_en       = CLK_ALL_ON;
                    next_reset_vector = 1'b1;
                end
                else if (tmr_expire)
                begin
                    next_state  = SMC_WAKE_HALT;
                    // restore halted domains, core and program memory still held
                    next_clk_en = CLK_ALL_ON
                        & ~5'(1 << CLK_CORE)
                        & ~5'(1 << CLK_PMEM);
                    tmr_load    = 1'b1;
                    tmr_val     = CNT_W'(WAKE_HALT_CYCLES);
                end
            end
            SMC_WAKE_HALT:
            begin
                if (reset_wake)
                begin
                    next_state        = SMC_ACTIVE;
                    next_clk_en       = CLK_ALL_ON;
                    next_reset_vector = 1'b1;
                end
                else if (tmr_expire)
                begin
                    next_state       = SMC_ACTIVE;
                    next_clk_en      = CLK_ALL_ON;
                    next_irq_service = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state              <= SMC_ACTIVE;
            cur_mode           <= SMC_IDLE;
            clk_en             <= CLK_ALL_ON;
            irq_service_start  <= 1'b0;
            reset_vector_start <= 1'b0;
            converter_start    <= 1'b0;
        end
        else
        begin
            state              <= next_state;
            cur_mode           <= next_cur_mode;
            clk_en             <= next_clk_en;
            irq_service_start  <= next_irq_service;
            reset_vector_start <= next_reset_vector;
            converter_start    <= next_conv_start;
        end
    end

    // =========================================================
    // registered status outputs
    // =========================================================
    logic next_sleeping;

    assign next_sleeping = (next_state != SMC_ACTIVE);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sleeping     <= 1'b0;
            storage_hold <= 1'b0;
            active_mode  <= 2'h0;
        end
        else
        begin
            sleeping     <= next_sleeping;
            // storage writes blocked across sleep and wake
            storage_hold <= next_sleeping;
            active_mode  <= 2'(next_cur_mode);
        end
    end

    assign core_clock_domain       = clk_en[CLK_CORE];
    assign program_memory_clock    = clk_en[CLK_PMEM];
    assign peripheral_clock_domain = clk_en[CLK_PERI];
    assign converter_clock_domain  = clk_en[CLK_CONV];
    assign oscillator_en           = clk_en[CLK_OSC];

endmodule

// file: design/smc_sync2.sv
module smc_sync2 import smc_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // =========================================================
    // two-stage synchroniser
    // =========================================================
    logic [W-1:0] stage1;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// file: design/smc_wake_timer.sv
module smc_wake_timer import smc_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // load and expiry
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              expire
);

    // =========================================================
    // down counter, expires on its last counted cycle
    // =========================================================
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb
    begin
        if (load)
            next_cnt = load_val;
        else if (cnt != '0)
            next_cnt = cnt - W'(1);
        else
            next_cnt = cnt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    assign expire = (cnt <= W'(1));

endmodule

// file: dv/sleep_mode_controller_bench.sv
module sleep_mode_controller_bench import smc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // signals
    // =========================================================
    logic       clk = 1'b0, rst = 1'b1, pcr_write = 1'b0, sleep_instr = 1'b0;
    logic [7:0] pcr_wdata = 8'h00;
    logic       crystal_clock_sel = 1'b1, converter_enabled = 1'b1;
    logic       external_interrupt_zero_irq = 1'b0, external_interrupt_zero_enabled = 1'b1, external_interrupt_zero_level_mode = 1'b0;
    logic       pin_change_irq = 1'b0, converter_done_irq = 1'b0;
    logic       timer_irq = 1'b0, comparator_irq = 1'b0, other_io_irq = 1'b0;
    logic       self_program_op_irq = 1'b0, watchdog_irq = 1'b0, go = 1'b0;
    logic       comparator_power_off = 1'b0, ext_reset_n = 1'b1;
    logic       watchdog_reset_req = 1'b0, brownout_reset_req = 1'b0;
    logic [7:0] power_control_reg;
    logic [1:0] active_mode;
    logic       irq_service_start, reset_vector_start, storage_hold, sleeping;
    logic       core_clock_domain, program_memory_clock, converter_start;
    logic       peripheral_clock_domain, converter_clock_domain, oscillator_en;
    logic       external_interrupt_zero;
    wire  [7:0] clocks = {3'h0, core_clock_domain, program_memory_clock,
                          peripheral_clock_domain, converter_clock_domain,
                          oscillator_en};
    int         n_errors = 0, n_tests = 0, n;
    int         wake_n[4] = '{6, 6, 7, 11};
    logic [7:0] pat[4] = '{8'h07, 8'h03, 8'h00, 8'h01};

    always #20 clk = ~clk;

    smc_sleep_controller #(.OSC_STARTUP_CYCLES(2)) smc_sleep_controller_i
    (
        .clk, .rst, .pcr_write, .pcr_wdata, .sleep_instr, .crystal_clock_sel,
        .power_control_reg, .irq_service_start, .reset_vector_start,
        .storage_hold, .sleeping, .active_mode, .core_clock_domain,
        .program_memory_clock, .peripheral_clock_domain,
        .converter_clock_domain, .oscillator_en, .converter_enabled,
        .converter_start, .external_interrupt_zero_irq, .external_interrupt_zero_enabled, .external_interrupt_zero_level_mode,
        .external_interrupt_zero, .pin_change_irq, .self_program_op_irq,
        .converter_done_irq, .timer_irq, .comparator_irq,
        .comparator_power_off, .other_io_irq, .watchdog_irq, .ext_reset_n,
        .watchdog_reset_req, .brownout_reset_req
    );

    smc_wake_model smc_wake_model_i
    (
        .clk, .go, .irq_service_start, .reset_vector_start,
        .pin(external_interrupt_zero)
    );

    // =========================================================
    // tasks
    // =========================================================
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", s, exp, seen);
            n_errors++;
        end
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] v);
        pcr_wdata = v;
        pcr_write = 1'b1;
        tick();
        pcr_write = 1'b0;
    endtask

    task automatic slp;
        sleep_instr = 1'b1;
        tick();
        sleep_instr = 1'b0;
    endtask

    // counts cycles until the chosen pulse, bounded
    task automatic wait_evt(input logic rv);
        n = 0;
        while ((rv ? reset_vector_start : irq_service_start) !== 1'b1)
        begin
            if (n == 40)
            begin
                $display("ERROR wake_pulse expected 1 seen 0");
                n_errors++;
                end_of_test();
            end
            tick();
            n++;
        end
    endtask

    // =========================================================
    // sequence of tests
    // =========================================================
    initial
    begin
        repeat (8) tick();
        rst = 1'b0;
        chk("pcr_reset", power_control_reg, 8'h00);
        chk("clocks_reset", clocks, 8'h1F);
        wr(8'hFF);
        chk("pcr_bits", power_control_reg, 8'h38);
        wr(8'h10);
        slp();
        chk("no_enable", sleeping, 1'b0);
        rst = 1'b1;
        tick();
        rst = 1'b0;
        chk("pcr_rereset", power_control_reg, 8'h00);
        $display("test reset_and_enable finished");

        for (int m = 0; m < 4; m++)
        begin
            converter_enabled = (m != 1);
            wr(8'h20 | 8'(m << 3));
            slp();
            chk("pattern", clocks, pat[m]);
            chk("mode", active_mode, 8'(m));
            chk("conv_start", converter_start, m == 0);
            chk("hold", storage_hold, 1'b1);
            repeat (9) tick();
            if (m > 0)
            begin
                {timer_irq, external_interrupt_zero_irq, comparator_irq, other_io_irq} = 4'hF;
                repeat (12) tick();
                chk("refused", clocks, pat[m]);
                {timer_irq, external_interrupt_zero_irq, comparator_irq, other_io_irq} = 4'h0;
                repeat (9) tick();
            end
            timer_irq = (m == 0);
            converter_done_irq = (m == 1);
            pin_change_irq = (m > 1);
            wait_evt(1'b0);
            chk("wake_cycles", 8'(n), 8'(wake_n[m]));
            chk("clocks_on", clocks, 8'h1F);
            chk("awake", sleeping, 1'b0);
            chk("hold_off", storage_hold, 1'b0);
            {timer_irq, converter_done_irq, pin_change_irq} = 3'h0;
            $display("test mode %0d finished", m);
        end

        for (int r = 0; r < 3; r++)
        begin
            crystal_clock_sel = (r != 0);
            wr(r == 0 ? 8'h38 : 8'h30);
            slp();
            chk("pdown_pattern", clocks, 8'h00);
            watchdog_reset_req = (r == 0);
            brownout_reset_req = (r == 1);
            ext_reset_n = (r != 2);
            wait_evt(1'b1);
            chk("reset_delay", 8'(n), r < 2 ? 8'h01 : 8'h03);
            chk("reset_clocks", clocks, 8'h1F);
            {watchdog_reset_req, brownout_reset_req, ext_reset_n} = 3'h1;
            tick();
        end
        crystal_clock_sel = 1'b1;
        $display("test reset_wake finished");

        external_interrupt_zero_level_mode = 1'b1;
        wr(8'h30);
        slp();
        repeat (9) tick();
        go = 1'b1;
        tick();
        go = 1'b0;
        wait_evt(1'b0);
        chk("level_cycles", 8'(n), 8'h09);
        chk("level_wake", sleeping, 1'b0);
        chk("level_clocks", clocks, 8'h1F);
        external_interrupt_zero_level_mode = 1'b0;
        repeat (2) tick();
        $display("test level_wake finished");
        end_of_test();
    end
endmodule

// file: dv/smc_monitor.sv
module smc_monitor import smc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // core side
    input wire logic       sleep_instr,
    input wire logic       crystal_clock_sel,
    input wire logic [7:0] power_control_reg,
    input wire logic       irq_service_start,
    input wire logic       reset_vector_start,
    input wire logic       sleeping,
    input wire logic [1:0] active_mode,
    // clock enables
    input wire logic       core_clock_domain,
    input wire logic       program_memory_clock,
    input wire logic       peripheral_clock_domain,
    input wire logic       converter_clock_domain,
    input wire logic       oscillator_en,
    // converter
    input wire logic       converter_enabled,
    input wire logic       converter_start,
    // wake sources
    input wire logic       external_interrupt_zero_irq,
    input wire logic       external_interrupt_zero,
    input wire logic       pin_change_irq,
    input wire logic       self_program_op_irq,
    input wire logic       converter_done_irq,
    input wire logic       timer_irq,
    input wire logic       comparator_irq,
    input wire logic       other_io_irq,
    input wire logic       watchdog_irq,
    input wire logic       ext_reset_n,
    input wire logic       watchdog_reset_req,
    input wire logic       brownout_reset_req
);
    // =========================================================
    // source history, so a quiet stretch can be recognised
    // =========================================================
    logic [7:0] hist_s, next_hist_s, hist_a, next_hist_a;
    logic       busy_s, busy_a;
    wire  [4:0] clocks = {core_clock_domain, program_memory_clock,
                          peripheral_clock_domain, converter_clock_domain,
                          oscillator_en};

    always_comb
    begin
        busy_s = pin_change_irq | converter_done_irq | self_program_op_irq
               | watchdog_irq | watchdog_reset_req | brownout_reset_req
               | ~external_interrupt_zero | ~ext_reset_n;
        busy_a = busy_s | external_interrupt_zero_irq | timer_irq | comparator_irq
               | other_io_irq;
        next_hist_s = rst ? 8'hFF : {hist_s[6:0], busy_s};
        next_hist_a = rst ? 8'hFF : {hist_a[6:0], busy_a};
    end

    always_ff @(posedge clk)
    begin
        hist_s <= next_hist_s;
        hist_a <= next_hist_a;
    end

    function automatic logic [4:0] pat_f(logic [1:0] m, logic x);
        case (m)
            2'h0: pat_f = 5'h07;
            2'h1: pat_f = 5'h03;
            2'h3: pat_f = x ? 5'h01 : 5'h00;
            default: pat_f = 5'h00;
        endcase
    endfunction

    // =========================================================
    // properties
    // =========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_enter;
        !sleeping && sleep_instr && power_control_reg[PCR_SE_BIT];
    endsequence
    sequence s_quiet_sleep;
        sleeping && hist_a == 8'h00 && !watchdog_reset_req
            && !brownout_reset_req;
    endsequence

    property p_enter;
        s_enter |=> sleeping && clocks ==
            pat_f($past(power_control_reg[4:3]), $past(crystal_clock_sel));
    endproperty
    property p_no_se;
        !sleeping && sleep_instr && !power_control_reg[PCR_SE_BIT]
            |=> !sleeping;
    endproperty
    property p_conv;
        s_enter |=> converter_start ==
            ($past(converter_enabled) && !$past(power_control_reg[4]));
    endproperty
    property p_refuse;
        sleeping && hist_s == 8'h00 && !busy_s
            && ((active_mode == 2'h1 && !peripheral_clock_domain)
            || (active_mode == 2'h2 && !oscillator_en))
            |=> $stable(peripheral_clock_domain) && $stable(oscillator_en);
    endproperty
    property p_service;
        irq_service_start |-> clocks == 5'h1F && !sleeping
            && !$past(core_clock_domain) && !$past(core_clock_domain, 4)
            && $past(peripheral_clock_domain, 4);
    endproperty
    property p_reset_wake;
        sleeping && (watchdog_reset_req || brownout_reset_req)
            |=> reset_vector_start && !sleeping && clocks == 5'h1F;
    endproperty
    property p_idle_wake;
        s_quiet_sleep ##0 (active_mode == 2'h0 && timer_irq)
            |-> ##6 irq_service_start;
    endproperty
    property p_standby_wake;
        s_quiet_sleep ##0 (active_mode == 2'h3 && oscillator_en
            && !peripheral_clock_domain && pin_change_irq)
            |-> ##11 irq_service_start;
    endproperty

    a_enter: assert property (p_enter)
        else $error("sleep entry clock pattern wrong");
    a_no_se: assert property (p_no_se)
        else $error("sleep entered with enable clear");
    a_conv: assert property (p_conv)
        else $error("converter start on entry wrong");
    a_refuse: assert property (p_refuse)
        else $error("woke on a source the mode excludes");
    a_service: assert property (p_service)
        else $error("service start without four halt cycles");
    a_reset_wake: assert property (p_reset_wake)
        else $error("reset did not wake to reset vector");
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle timer wake not serviced in six cycles");
    a_standby_wake: assert property (p_standby_wake)
        else $error("standby wake not serviced in eleven cycles");
endmodule

bind smc_sleep_controller smc_monitor smc_monitor_i
(
    .clk, .rst, .sleep_instr, .crystal_clock_sel, .power_control_reg,
    .irq_service_start, .reset_vector_start, .sleeping, .active_mode,
    .core_clock_domain, .program_memory_clock, .peripheral_clock_domain,
    .converter_clock_domain, .oscillator_en, .converter_enabled,
    .converter_start, .external_interrupt_zero_irq, .external_interrupt_zero, .pin_change_irq,
    .self_program_op_irq, .converter_done_irq, .timer_irq, .comparator_irq,
    .other_io_irq, .watchdog_irq, .ext_reset_n, .watchdog_reset_req,
    .brownout_reset_req
);

// file: dv/smc_wake_model.sv
module smc_wake_model
(
    // clock
    input  wire logic clk,
    // request and core answers
    input  wire logic go,
    input  wire logic irq_service_start,
    input  wire logic reset_vector_start,
    // wake pin, pulled up when released
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pin = 1'b1;

    // level held until the core reaches the service routine or the reset vector
    always @(posedge clk)
    begin
        if (go)
            pin <= 1'b0;
        else if (irq_service_start || reset_vector_start)
            pin <= 1'b1;
    end
endmodule
